// ===== acc_comparator_ctrl.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module acc_comparator_ctrl #(
	parameter int LEVEL_W = 10
) (
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [acc_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [LEVEL_W-1:0]            positive_input_pin,
	input  wire logic [LEVEL_W-1:0]            negative_input_pin,
	input  wire logic [7:0][LEVEL_W-1:0]       analog_channel_pins,
	input  wire logic [LEVEL_W-1:0]            bandgap_level,
	input  wire logic [2:0]                    channel_select,
	input  wire logic                          converter_enable,
	input  wire logic                          converter_power_off,
	input  wire logic                          global_irq_enable,
	input  wire logic                          irq_vector_taken,
	input  wire logic                          capture_irq_enable,
	input  wire logic                          positive_pin_digital,
	input  wire logic                          negative_pin_digital,
	output logic                               compare_irq,
	output logic                               capture_input,
	output logic                               capture_irq_allowed,
	output logic                               output_pin_o,
	output logic                               output_pin_oe,
	output logic                               positive_pin_read,
	output logic                               negative_pin_read,
	output logic                               positive_buffer_on,
	output logic                               negative_buffer_on,
	output logic                               comparator_power_on,
	output logic                               negative_from_channel,
	output logic                               positive_from_bandgap
);

	// ************************************************
	// register state
	// ************************************************
	acc_pkg::acc_ctrl_t    ctrl_q;
	acc_pkg::acc_buf_dis_t buf_dis_q;
	logic                  output_pin_enable_q;
	logic                  negative_mux_enable_q;
	logic                  compare_event_flag_q;
	logic                  compare_event_flag_d;
	logic                  sync1_q;
	logic                  sync2_q;
	logic                  prev_q;
	logic [31:0]           prdata_q;

	logic                  raw_result;
	logic [LEVEL_W-1:0]    pos_level;
	logic [LEVEL_W-1:0]    neg_level;
	logic                  compare_event;
	logic                  rise_evt;
	logic                  fall_evt;
	logic                  wr_access;
	logic                  setup_phase;
	logic                  hit_route;
	logic                  hit_conv_b;
	logic                  hit_ctrl;
	logic                  hit_buf_dis;
	logic                  hit_any;
	logic                  flag_wr_clear;
	logic                  flag_clear;
	logic [7:0]            rd_byte;

	function automatic logic addr_hit(
		input logic [acc_pkg::ADDR_W-1:0] a,
		input logic [7:0]                 idx
	);
		logic [acc_pkg::ADDR_W-1:0] byte_addr;
		byte_addr = {idx[acc_pkg::ADDR_W-3:0], 2'b00};
		return a == byte_addr;
	endfunction

	// ************************************************
	// apb decode
	// ************************************************
	assign setup_phase = psel & ~penable;
	assign wr_access   = psel & penable & pwrite;
	assign hit_route   = addr_hit(paddr, acc_pkg::ROUTE_IDX);
	assign hit_conv_b  = addr_hit(paddr, acc_pkg::CONV_B_IDX);
	assign hit_ctrl    = addr_hit(paddr, acc_pkg::CTRL_IDX);
	assign hit_buf_dis = addr_hit(paddr, acc_pkg::BUF_DIS_IDX);
	assign hit_any     = hit_route | hit_conv_b | hit_ctrl | hit_buf_dis;

	// no wait states: read data is staged during the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit_any;
	assign prdata  = prdata_q;

	always_comb
	begin
		rd_byte = 8'h00;
		if (hit_route)
		begin
			rd_byte[acc_pkg::ROUTE_OE_BIT] = output_pin_enable_q;
		end
		if (hit_conv_b)
		begin
			rd_byte[acc_pkg::MUX_EN_BIT] = negative_mux_enable_q;
		end
		if (hit_ctrl)
		begin
			rd_byte[acc_pkg::DISABLE_BIT] = ctrl_q.disable_cmp;
			rd_byte[acc_pkg::BANDGAP_BIT] = ctrl_q.bandgap_sel;
			rd_byte[acc_pkg::OUTPUT_BIT]  = sync2_q;
			rd_byte[acc_pkg::FLAG_BIT]    = compare_event_flag_q;
			rd_byte[acc_pkg::IRQ_EN_BIT]  = ctrl_q.irq_en;
			rd_byte[acc_pkg::CAPTURE_BIT] = ctrl_q.capture_route;
			rd_byte[acc_pkg::MODE_HI_BIT:acc_pkg::MODE_LO_BIT] = ctrl_q.edge_mode;
		end
		if (hit_buf_dis)
		begin
			rd_byte[acc_pkg::NEG_BUF_BIT] = buf_dis_q.negative_buffer_disable;
			rd_byte[acc_pkg::POS_BUF_BIT] = buf_dis_q.positive_buffer_disable;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prdata_q <= 32'h0000_0000;
		end
		else if (setup_phase & ~pwrite)
		begin
			prdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// ************************************************
	// software registers
	// ************************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			output_pin_enable_q <= acc_pkg::ROUTE_RST[acc_pkg::ROUTE_OE_BIT];
		end
		else if (wr_access & hit_route)
		begin
			output_pin_enable_q <= pwdata[acc_pkg::ROUTE_OE_BIT];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			negative_mux_enable_q <= acc_pkg::CONV_B_RST[acc_pkg::MUX_EN_BIT];
		end
		else if (wr_access & hit_conv_b)
		begin
			negative_mux_enable_q <= pwdata[acc_pkg::MUX_EN_BIT];
		end
	end

	// edge mode and disable changes can glitch the flag; software masks first
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_q <= acc_pkg::acc_ctrl_t'({acc_pkg::CTRL_RST[7:6], acc_pkg::CTRL_RST[3:0]});
		end
		else if (wr_access & hit_ctrl)
		begin
			ctrl_q.disable_cmp   <= pwdata[acc_pkg::DISABLE_BIT];
			ctrl_q.bandgap_sel   <= pwdata[acc_pkg::BANDGAP_BIT];
			ctrl_q.irq_en        <= pwdata[acc_pkg::IRQ_EN_BIT];
			ctrl_q.capture_route <= pwdata[acc_pkg::CAPTURE_BIT];
			ctrl_q.edge_mode     <= acc_pkg::acc_edge_mode_t'(
				pwdata[acc_pkg::MODE_HI_BIT:acc_pkg::MODE_LO_BIT]);
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			buf_dis_q <= acc_pkg::acc_buf_dis_t'(acc_pkg::BUF_DIS_RST[1:0]);
		end
		else if (wr_access & hit_buf_dis)
		begin
			buf_dis_q.negative_buffer_disable <= pwdata[acc_pkg::NEG_BUF_BIT];
			buf_dis_q.positive_buffer_disable <= pwdata[acc_pkg::POS_BUF_BIT];
		end
	end

	// ************************************************
	// input selection and comparison
	// ************************************************
	// channel mux belongs to the converter; unusable while it is powered down
	assign negative_from_channel = negative_mux_enable_q & ~converter_enable
		& ~converter_power_off;
	assign neg_level = negative_from_channel ? analog_channel_pins[channel_select]
		: negative_input_pin;
	assign positive_from_bandgap = ctrl_q.bandgap_sel;
	assign pos_level = ctrl_q.bandgap_sel ? bandgap_level : positive_input_pin;
	assign comparator_power_on = ~ctrl_q.disable_cmp;
	// a powered-off comparator rests low
	assign raw_result = comparator_power_on & (pos_level > neg_level);

	// ************************************************
	// synchroniser and edge detect
	// ************************************************
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= raw_result;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prev_q <= 1'b0;
		end
		else
		begin
			prev_q <= sync2_q;
		end
	end

	assign rise_evt = sync2_q & ~prev_q;
	assign fall_evt = ~sync2_q & prev_q;

	always_comb
	begin
		unique case (ctrl_q.edge_mode)
			acc_pkg::ACC_EDGE_TOGGLE:   compare_event = rise_evt | fall_evt;
			acc_pkg::ACC_EDGE_RESERVED: compare_event = 1'b0;
			acc_pkg::ACC_EDGE_FALL:     compare_event = fall_evt;
			acc_pkg::ACC_EDGE_RISE:     compare_event = rise_evt;
		endcase
	end

	// ************************************************
	// event flag and interrupt
	// ************************************************
	assign flag_wr_clear = wr_access & hit_ctrl & pwdata[acc_pkg::FLAG_BIT];
	assign flag_clear    = flag_wr_clear | irq_vector_taken;
	// a new event beats a clear in the same cycle
	assign compare_event_flag_d = compare_event | (compare_event_flag_q & ~flag_clear);

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			compare_event_flag_q <= acc_pkg::CTRL_RST[acc_pkg::FLAG_BIT];
		end
		else
		begin
			compare_event_flag_q <= compare_event_flag_d;
		end
	end

	assign compare_irq = compare_event_flag_q & ctrl_q.irq_en & global_irq_enable;

	// ************************************************
	// output routing and pin buffers
	// ************************************************
	assign capture_input       = ctrl_q.capture_route & sync2_q;
	assign capture_irq_allowed = ctrl_q.capture_route & capture_irq_enable;
	assign output_pin_o        = output_pin_enable_q & sync2_q;
	assign output_pin_oe       = output_pin_enable_q;
	assign positive_buffer_on  = ~buf_dis_q.positive_buffer_disable;
	assign negative_buffer_on  = ~buf_dis_q.negative_buffer_disable;
	assign positive_pin_read   = positive_pin_digital & ~buf_dis_q.positive_buffer_disable;
	assign negative_pin_read   = negative_pin_digital & ~buf_dis_q.negative_buffer_disable;

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_route_read;
		psel & ~penable & ~pwrite & hit_route;
	endsequence

	sequence s_access;
		psel & penable;
	endsequence

	sequence s_event_no_clear;
		compare_event;
	endsequence

	neg_mux_sel_a: assert property (negative_from_channel
		|-> neg_level == analog_channel_pins[channel_select])
		else $error("negative input not the selected channel");

	neg_pin_sel_a: assert property ((~negative_mux_enable_q | converter_enable)
		|-> neg_level == negative_input_pin)
		else $error("negative input not the dedicated pin");

	cmp_result_a: assert property (comparator_power_on
		|-> raw_result == (pos_level > neg_level))
		else $error("comparator result wrong");

	pos_bandgap_a: assert property (ctrl_q.bandgap_sel |-> pos_level == bandgap_level)
		else $error("bandgap not on positive input");

	pos_pin_a: assert property (~ctrl_q.bandgap_sel |-> pos_level == positive_input_pin)
		else $error("positive pin not on positive input");

	sync_delay_a: assert property ($changed(raw_result) ##1 $stable(raw_result)
		|=> sync2_q == $past(raw_result, 2))
		else $error("synchronised output late or wrong");

	mode_reserved_a: assert property (ctrl_q.edge_mode == acc_pkg::ACC_EDGE_RESERVED
		|-> ~compare_event)
		else $error("reserved mode produced an event");

	flag_set_a: assert property (s_event_no_clear |=> compare_event_flag_q)
		else $error("flag not set on event");

	flag_clear_a: assert property ((irq_vector_taken & ~compare_event)
		|=> ~compare_event_flag_q)
		else $error("flag not cleared by vector");

	irq_gate_a: assert property (compare_irq
		== (compare_event_flag_q & ctrl_q.irq_en & global_irq_enable))
		else $error("interrupt request gating wrong");

	power_off_a: assert property (ctrl_q.disable_cmp [*3] |-> ~sync2_q)
		else $error("disabled comparator output not low");

	cap_route_a: assert property (~ctrl_q.capture_route |-> ~capture_input)
		else $error("capture fed while route off");

	route_rsvd_a: assert property (s_route_read ##1 s_access
		|-> prdata[31:1] == 31'h0000_0000 && prdata[0] == output_pin_enable_q)
		else $error("output route readback wrong");

	out_pin_a: assert property (output_pin_enable_q |-> output_pin_o == sync2_q)
		else $error("output pin not driven");

	buf_dis_a: assert property (buf_dis_q.positive_buffer_disable
		|-> ~positive_pin_read && ~positive_buffer_on)
		else $error("disabled buffer still reads");

	mux_power_a: assert property (converter_power_off |-> ~negative_from_channel)
		else $error("channel mux used while powered down");

	edge_cmp_a: assert property ($rose(sync2_q)
		&& ctrl_q.edge_mode == acc_pkg::ACC_EDGE_TOGGLE |-> compare_event)
		else $error("toggle edge missed");

endmodule

// ===== acc_pkg.sv
// Behaviour
// - with mux enabled and converter off, channel select picks channel 0..7 as negative input
// - mux disabled or converter on: dedicated negative pin drives the negative input
// - comparator output is one while positive input exceeds negative input
// - bandgap select set feeds the internal bandgap to the positive input
// - bandgap select clear applies the positive pin to the positive input
// - readable output passes a synchroniser, appearing one to two cycles late
// - edge mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - flag sets when a synchronised output event matches the selected edge mode
// - flag clears when its vector is taken or software writes one
// - interrupt request only while interrupt enable and global enable are both set
// - disable bit powers the comparator off at any time; zero restores it
// - capture route bit feeds the output to timer capture; else no connection
// - timer capture interrupt needs the timer capture interrupt enable too
// - output pin enable drives the comparator output onto its pin
// - output-route bits 7:1 read zero; bit 0 read/write, resets to zero
// - buffer disable bit turns off the pin buffer and forces pin read to zero
// - channel mux usable only while converter power-off is cleared
package acc_pkg;

	// ************************************************
	// register map (indices; byte address is index times four)
	// ************************************************
	localparam int           ADDR_W         = 8;
	localparam logic [7:0]   ROUTE_IDX      = 8'h2F;
	localparam logic [7:0]   CONV_B_IDX     = 8'h30;
	localparam logic [7:0]   CTRL_IDX       = 8'h31;
	localparam logic [7:0]   BUF_DIS_IDX    = 8'h32;

	// ************************************************
	// field positions
	// ************************************************
	localparam int           ROUTE_OE_BIT   = 0;
	localparam int           MUX_EN_BIT     = 6;
	localparam int           DISABLE_BIT    = 7;
	localparam int           BANDGAP_BIT    = 6;
	localparam int           OUTPUT_BIT     = 5;
	localparam int           FLAG_BIT       = 4;
	localparam int           IRQ_EN_BIT     = 3;
	localparam int           CAPTURE_BIT    = 2;
	localparam int           MODE_HI_BIT    = 1;
	localparam int           MODE_LO_BIT    = 0;
	localparam int           NEG_BUF_BIT    = 1;
	localparam int           POS_BUF_BIT    = 0;

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [7:0]   ROUTE_RST      = 8'h00;
	localparam logic [7:0]   CONV_B_RST     = 8'h00;
	localparam logic [7:0]   CTRL_RST       = 8'h00;
	localparam logic [7:0]   BUF_DIS_RST    = 8'h00;

	// ************************************************
	// edge modes
	// ************************************************
	typedef enum logic [1:0] {
		ACC_EDGE_TOGGLE,
		ACC_EDGE_RESERVED,
		ACC_EDGE_FALL,
		ACC_EDGE_RISE
	} acc_edge_mode_t;

	typedef struct packed {
		logic           disable_cmp;
		logic           bandgap_sel;
		logic           irq_en;
		logic           capture_route;
		acc_edge_mode_t edge_mode;
	} acc_ctrl_t;

	typedef struct packed {
		logic           negative_buffer_disable;
		logic           positive_buffer_disable;
	} acc_buf_dis_t;

endpackage

// ===== acc_analog_model.sv
`timescale 1ns/1ps
module acc_analog_model #(
	parameter int LEVEL_W = 10
) (
	input  wire logic                    ref_clk,
	input  wire logic                    capture_input,
	output logic [LEVEL_W-1:0]           positive_input_pin,
	output logic [LEVEL_W-1:0]           negative_input_pin,
	output logic [7:0][LEVEL_W-1:0]      analog_channel_pins,
	output logic [LEVEL_W-1:0]           bandgap_level,
	output logic                         positive_pin_digital,
	output logic                         negative_pin_digital
);
	// ************************************************
	// pin levels
	// ************************************************
	logic cap_prev;
	int   capture_count;
	// channel i sits at i*100+50, so a threshold between two of them tells the pick
	initial
	begin
		for (int i = 0; i < 8; i++)
			analog_channel_pins[i] = LEVEL_W'(i * 100 + 50);
		bandgap_level        = 10'h258;
		positive_input_pin   = 10'h000;
		negative_input_pin   = 10'h190;
		positive_pin_digital = 1'b1;
		negative_pin_digital = 1'b1;
		cap_prev             = 1'b0;
		capture_count        = 0;
	end
	task set_levels(input logic [LEVEL_W-1:0] p, input logic [LEVEL_W-1:0] n);
		positive_input_pin <= p;
		negative_input_pin <= n;
	endtask
	// ************************************************
	// timer capture front end: counts rising edges
	// ************************************************
	always @(posedge ref_clk)
	begin
		cap_prev <= capture_input;
		if (capture_input === 1'b1 && cap_prev === 1'b0)
			capture_count <= capture_count + 1;
	end
endmodule

// ===== analog_comparator_control_tb_top.sv
`timescale 1ns/1ps
module analog_comparator_control_tb_top;
	logic              ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rdata;
	logic [9:0]        pos_pin, neg_pin, bg_lvl;
	logic [7:0][9:0]   chan;
	logic [2:0]        channel_select;
	logic              converter_enable, converter_power_off, global_irq_enable;
	logic              irq_vector_taken, capture_irq_enable, pos_dig, neg_dig, rerr;
	logic              compare_irq, capture_input, capture_irq_allowed;
	logic              output_pin_o, output_pin_oe, positive_pin_read, negative_pin_read;
	logic              positive_buffer_on, negative_buffer_on, comparator_power_on;
	logic              negative_from_channel, positive_from_bandgap;
	int                bad_count, total_checks, cycles, c0;

	acc_comparator_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.positive_input_pin(pos_pin), .negative_input_pin(neg_pin),
		.analog_channel_pins(chan), .bandgap_level(bg_lvl),
		.channel_select(channel_select), .converter_enable(converter_enable),
		.converter_power_off(converter_power_off), .global_irq_enable(global_irq_enable),
		.irq_vector_taken(irq_vector_taken), .capture_irq_enable(capture_irq_enable),
		.positive_pin_digital(pos_dig), .negative_pin_digital(neg_dig),
		.compare_irq(compare_irq), .capture_input(capture_input),
		.capture_irq_allowed(capture_irq_allowed), .output_pin_o(output_pin_o),
		.output_pin_oe(output_pin_oe), .positive_pin_read(positive_pin_read),
		.negative_pin_read(negative_pin_read), .positive_buffer_on(positive_buffer_on),
		.negative_buffer_on(negative_buffer_on), .comparator_power_on(comparator_power_on),
		.negative_from_channel(negative_from_channel),
		.positive_from_bandgap(positive_from_bandgap));

	acc_analog_model u_model (.ref_clk(ref_clk), .capture_input(capture_input),
		.positive_input_pin(pos_pin), .negative_input_pin(neg_pin),
		.analog_channel_pins(chan), .bandgap_level(bg_lvl),
		.positive_pin_digital(pos_dig), .negative_pin_digital(neg_dig));

	// ************************************************
	// clock and timeout
	// ************************************************
	always #10 ref_clk = ~ref_clk;
	// whole run is a few hundred cycles; a hang shows up well before this
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	// ************************************************
	// tasks
	// ************************************************
	task wrap_up;
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	// apb transfer; byte address is four times the register index
	task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// raw result high: 600 against 400, low: 200 against 400
	task drive(input logic p);
		@(posedge ref_clk);
		u_model.set_levels(p ? 10'h258 : 10'h0C8, 10'h190);
		#1;
	endtask
	task rd_out(input logic exp);
		tick(4);
		xfer(1'b0, acc_pkg::CTRL_IDX, 32'h0);
		chk(rdata[acc_pkg::OUTPUT_BIT], exp);
	endtask

	// ************************************************
	// sequence
	// ************************************************
	initial
	begin
		ref_clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = 8'h00; pwdata = 32'h0; channel_select = 3'h0; converter_enable = 0;
		converter_power_off = 0; global_irq_enable = 0; irq_vector_taken = 0;
		capture_irq_enable = 0; bad_count = 0; total_checks = 0; cycles = 0;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b0, 8'(acc_pkg::ROUTE_IDX + i), 32'h0);
			chk(rdata, 32'h0);
		end
		xfer(1'b0, 8'h33, 32'h0);
		// compared apart: the compare task is one word wide and would drop the error bit
		chk(rerr, 1'b1);
		chk(rdata, 32'h0);
		xfer(1'b1, acc_pkg::ROUTE_IDX, 32'hFF);
		xfer(1'b0, acc_pkg::ROUTE_IDX, 32'h0);
		chk(rdata, 32'h1);
		chk(output_pin_oe, 1'b1);
		// negative mux: positive at 320, dedicated negative pin at 1000
		xfer(1'b1, acc_pkg::CONV_B_IDX, 32'h40);
		@(posedge ref_clk);
		u_model.set_levels(10'h140, 10'h3E8);
		for (int ch = 0; ch < 8; ch++)
		begin
			@(posedge ref_clk);
			channel_select <= ch[2:0];
			rd_out(ch <= 2);
			chk(negative_from_channel, 1'b1);
		end
		@(posedge ref_clk);
		channel_select <= 3'h0;
		converter_enable <= 1'b1;
		rd_out(1'b0);
		chk(negative_from_channel, 1'b0);
		@(posedge ref_clk);
		converter_enable <= 1'b0;
		converter_power_off <= 1'b1;
		rd_out(1'b0);
		xfer(1'b1, acc_pkg::CONV_B_IDX, 32'h0);
		// bandgap 600 beats negative 500, pin 100 does not
		@(posedge ref_clk);
		u_model.set_levels(10'h064, 10'h1F4);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h40);
		rd_out(1'b1);
		chk(positive_from_bandgap, 1'b1);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h0);
		rd_out(1'b0);
		// edge modes, interrupt enable kept clear while changing them
		for (int m = 0; m < 4; m++)
		begin
			drive(1'b0);
			xfer(1'b1, acc_pkg::CTRL_IDX, 32'h10 | m);
			drive(1'b1);
			tick(4);
			xfer(1'b0, acc_pkg::CTRL_IDX, 32'h0);
			chk(rdata[acc_pkg::FLAG_BIT], m == 0 || m == 3);
			xfer(1'b1, acc_pkg::CTRL_IDX, 32'h10 | m);
			drive(1'b0);
			tick(4);
			xfer(1'b0, acc_pkg::CTRL_IDX, 32'h0);
			chk(rdata[acc_pkg::FLAG_BIT], m == 0 || m == 2);
		end
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h13);
		drive(1'b1);
		tick(4);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h0B);
		chk(compare_irq, 1'b0);
		@(posedge ref_clk);
		global_irq_enable <= 1'b1;
		#1;
		chk(compare_irq, 1'b1);
		@(posedge ref_clk);
		irq_vector_taken <= 1'b1;
		@(posedge ref_clk);
		irq_vector_taken <= 1'b0;
		#1;
		chk(compare_irq, 1'b0);
		drive(1'b0);
		tick(4);
		drive(1'b1);
		tick(4);
		chk(compare_irq, 1'b1);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h1B);
		chk(compare_irq, 1'b0);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h03);
		// output pin follows the synchronised result
		drive(1'b0);
		tick(4);
		drive(1'b1);
		chk(output_pin_o, 1'b0);
		tick(2);
		chk(output_pin_o, 1'b1);
		// capture routing
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h04);
		chk(capture_input, 1'b1);
		@(posedge ref_clk);
		capture_irq_enable <= 1'b1;
		#1;
		chk(capture_irq_allowed, 1'b1);
		c0 = u_model.capture_count;
		drive(1'b0);
		tick(4);
		drive(1'b1);
		tick(4);
		chk(u_model.capture_count, c0 + 1);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h0);
		chk({capture_input, capture_irq_allowed}, 2'b00);
		// power down with the raw result high
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h80);
		chk(comparator_power_on, 1'b0);
		rd_out(1'b0);
		xfer(1'b1, acc_pkg::CTRL_IDX, 32'h0);
		rd_out(1'b1);
		chk(comparator_power_on, 1'b1);
		// digital buffers
		chk({positive_pin_read, negative_pin_read}, 2'b11);
		xfer(1'b1, acc_pkg::BUF_DIS_IDX, 32'h3);
		chk({positive_pin_read, negative_pin_read}, 2'b00);
		chk({positive_buffer_on, negative_buffer_on}, 2'b00);
		xfer(1'b0, acc_pkg::BUF_DIS_IDX, 32'h0);
		chk(rdata, 32'h3);
		wrap_up();
	end
endmodule
